// ---- logic/rpsm_port.sv ----
`timescale 1ns/1ps
// One receive port: sticky flags, frequency and sensor bytes
module rpsm_port
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  // Video timing and link events
  input  wire logic        i_frame_start,
  input  wire logic        i_line_end,
  input  wire logic [15:0] i_line_length,
  input  wire logic        i_encoding_error,
  input  wire logic        i_buffer_overflow,
  input  wire logic        i_video_rx_error,
  input  wire logic        i_receiver_locked,
  // Frequency detector
  input  wire logic [7:0]  i_freq_integer_mhz,
  input  wire logic [7:0]  i_freq_fraction_mhz,
  input  wire logic        i_freq_measure_settled,
  input  wire logic [7:0]  i_low_freq_threshold,
  // Forward channel sensor status
  input  wire logic        i_sensor_valid,
  input  wire logic        i_sensor_index,
  input  wire logic [7:0]  i_sensor_data,
  // Clear-on-read strobe
  input  wire logic        i_status_read,
  // State
  output logic [7:0]       o_status,
  output logic [7:0]       o_freq_integer,
  output logic [7:0]       o_freq_fraction,
  output logic [7:0]       o_sensor_zero,
  output logic [7:0]       o_sensor_one,
  output logic             o_receiver_locked
);

  typedef struct packed
  {
    rpsm_pkg::rpsm_ftrk_t ftrk;
    logic [15:0]          ref_len;
    logic [15:0]          last_len;
    logic [15:0]          line_cnt;
    logic [15:0]          prev_cnt;
    logic                 have_ref;
    logic                 frame_bad;
    logic [7:0]           sticky;
    logic [7:0]           freq_int;
    logic [7:0]           freq_frac;
    logic                 settled;
    logic                 absent;
    logic [7:0]           sens0;
    logic [7:0]           sens1;
    logic                 locked;
  } rpsm_port_st_t;

  rpsm_port_st_t st_ff;
  rpsm_port_st_t nxt_st;
  logic [7:0]    ev;

  // Frame tracking, flag setting and status loading
  always_comb
  begin
    nxt_st = st_ff;
    ev     = 8'h00;
    if (i_frame_start)
    begin
      if (st_ff.ftrk != rpsm_pkg::FT_IDLE)
      begin
        if (st_ff.frame_bad)
          ev[rpsm_pkg::BIT_LINE_LENGTH_UNSTABLE_FLAG] = 1'b1;
        if (st_ff.have_ref && st_ff.line_cnt != st_ff.prev_cnt)
          ev[rpsm_pkg::BIT_LINE_CNT_CHANGED] = 1'b1;
        nxt_st.prev_cnt = st_ff.line_cnt;
        nxt_st.have_ref = 1'b1;
      end
      nxt_st.ftrk      = rpsm_pkg::FT_FRAME;
      nxt_st.line_cnt  = 16'h0000;
      nxt_st.frame_bad = 1'b0;
    end
    else if (i_line_end && st_ff.ftrk == rpsm_pkg::FT_FRAME)
    begin
      nxt_st.line_cnt = st_ff.line_cnt + 16'h0001;
      if (st_ff.line_cnt != 16'h0000 && i_line_length != st_ff.last_len)
        nxt_st.frame_bad = 1'b1;
      if (st_ff.ref_len != i_line_length && st_ff.have_ref)
        ev[rpsm_pkg::BIT_LINE_LEN_CHANGED] = 1'b1;
      nxt_st.last_len = i_line_length;
      nxt_st.ref_len  = i_line_length;
    end
    ev[rpsm_pkg::BIT_ENCODING_ERROR] = i_encoding_error;
    ev[rpsm_pkg::BIT_BUFFER_ERROR]   = i_buffer_overflow;
    // Set beats clear-on-read in the same cycle
    nxt_st.sticky = (i_status_read ? 8'h00 : st_ff.sticky) | ev;
    nxt_st.freq_int  = i_freq_integer_mhz;
    nxt_st.freq_frac = i_freq_fraction_mhz;
    nxt_st.settled   = i_freq_measure_settled;
    nxt_st.absent    = (i_freq_integer_mhz < i_low_freq_threshold);
    nxt_st.locked    = i_receiver_locked;
    if (i_sensor_valid)
    begin
      if (i_sensor_index)
        nxt_st.sens1 = i_sensor_data;
      else
        nxt_st.sens0 = i_sensor_data;
    end
  end

  // State register
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // Status byte assembly
  always_comb
  begin
    o_status = st_ff.sticky;
    o_status[rpsm_pkg::BIT_VIDEO_RX_ERROR] = i_video_rx_error;
    o_status[rpsm_pkg::BIT_FREQ_SETTLED]   = st_ff.settled;
    o_status[rpsm_pkg::BIT_CLOCK_ABSENT]   = st_ff.absent;
  end

  assign o_freq_integer    = st_ff.freq_int;
  assign o_freq_fraction   = st_ff.freq_frac;
  assign o_sensor_zero     = st_ff.sens0;
  assign o_sensor_one      = st_ff.sens1;
  assign o_receiver_locked = st_ff.locked;

endmodule

// ---- logic/rpsm_pkg.sv ----
package rpsm_pkg;

  // Register offsets on the internal register port
  localparam logic [7:0] ADDR_PORT_SELECT      = 8'h4c;
  localparam logic [7:0] ADDR_PORT_STATUS_TWO  = 8'h4e;
  localparam logic [7:0] ADDR_FREQ_INTEGER     = 8'h4f;
  localparam logic [7:0] ADDR_FREQ_FRACTION    = 8'h50;
  localparam logic [7:0] ADDR_SENSOR_ZERO      = 8'h51;
  localparam logic [7:0] ADDR_SENSOR_ONE       = 8'h52;

  // Status register field positions
  localparam int BIT_LINE_LENGTH_UNSTABLE_FLAG = 7;
  localparam int BIT_LINE_LEN_CHANGED  = 6;
  localparam int BIT_ENCODING_ERROR    = 5;
  localparam int BIT_BUFFER_ERROR      = 4;
  localparam int BIT_VIDEO_RX_ERROR    = 3;
  localparam int BIT_FREQ_SETTLED      = 2;
  localparam int BIT_CLOCK_ABSENT      = 1;
  localparam int BIT_LINE_CNT_CHANGED  = 0;

  // Port-select layout: read port number in [7:6], other bits only stored and read back
  localparam int SEL_RD_PORT_LSB = 6;
  localparam int NUM_PORTS       = 4;

  // Reset values
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] RST_SELECT = 8'h01;

  // Frame tracking states
  typedef enum logic [1:0]
  {
    FT_IDLE  = 2'b00,
    FT_FRAME = 2'b01,
    FT_DONE  = 2'b10
  } rpsm_ftrk_t;

endpackage

// ---- logic/rpsm_monitor.sv ----
`timescale 1ns/1ps
// Operation
// - Unequal lines in a frame set sticky unstable
// - Line length change sets sticky flag
// - Link encoding error sets sticky flag
// - Packet buffer overflow sets sticky flag
// - Video receive error bit, read-only, not cleared
// - Clock absent while frequency below threshold
// - Line count change sets sticky flag
// - Integer link frequency MHz byte
// - Fractional frequency byte in 1/256 MHz
// - Sensor status bytes loaded from forward channel
// - Per-port registers chosen by port select
// - Per-port lock indication
module rpsm_monitor
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  // Register port
  input  wire logic        i_reg_rd,
  input  wire logic        i_reg_wr,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic [7:0]       o_reg_rdata,
  output logic             o_reg_rvalid,
  // Per-port video timing and events
  input  wire logic [3:0]  i_frame_start,
  input  wire logic [3:0]  i_line_end,
  input  wire logic [63:0] i_line_length,
  input  wire logic [3:0]  i_encoding_error,
  input  wire logic [3:0]  i_buffer_overflow,
  input  wire logic [3:0]  i_video_rx_error,
  input  wire logic [3:0]  i_receiver_locked,
  // Per-port frequency detector, low-frequency threshold shared by all ports
  input  wire logic [31:0] i_freq_integer_mhz,
  input  wire logic [31:0] i_freq_fraction_mhz,
  input  wire logic [3:0]  i_freq_measure_settled,
  input  wire logic [7:0]  i_low_freq_threshold,
  // Per-port forward channel sensor status
  input  wire logic [3:0]  i_sensor_valid,
  input  wire logic [3:0]  i_sensor_index,
  input  wire logic [31:0] i_sensor_data,
  // Lock indications
  output logic [3:0]       o_receiver_locked
);

  typedef struct packed
  {
    logic [7:0] port_sel;
    logic [7:0] rdata;
    logic       rvalid;
    logic [3:0] locked;
  } rpsm_top_st_t;

  rpsm_top_st_t st_ff;
  rpsm_top_st_t nxt_st;
  logic [1:0]   rd_port;
  logic [3:0]   status_read;
  logic [7:0]   p_status [rpsm_pkg::NUM_PORTS];
  logic [7:0]   p_fint   [rpsm_pkg::NUM_PORTS];
  logic [7:0]   p_ffrac  [rpsm_pkg::NUM_PORTS];
  logic [7:0]   p_sens0  [rpsm_pkg::NUM_PORTS];
  logic [7:0]   p_sens1  [rpsm_pkg::NUM_PORTS];
  logic [3:0]   p_lock;

  assign rd_port = st_ff.port_sel[rpsm_pkg::SEL_RD_PORT_LSB +: 2];

  // Port instances with clear-on-read to the selected port only
  genvar g;
  generate
    for (g = 0; g < rpsm_pkg::NUM_PORTS; g++)
    begin : g_port
      assign status_read[g] = i_reg_rd && i_reg_addr == rpsm_pkg::ADDR_PORT_STATUS_TWO
                              && rd_port == 2'(g);
      rpsm_port u_port
      (
        .i_mclk                 (i_mclk),
        .i_nrst                 (i_nrst),
        .i_frame_start          (i_frame_start[g]),
        .i_line_end             (i_line_end[g]),
        .i_line_length          (i_line_length[16*g +: 16]),
        .i_encoding_error       (i_encoding_error[g]),
        .i_buffer_overflow      (i_buffer_overflow[g]),
        .i_video_rx_error       (i_video_rx_error[g]),
        .i_receiver_locked      (i_receiver_locked[g]),
        .i_freq_integer_mhz     (i_freq_integer_mhz[8*g +: 8]),
        .i_freq_fraction_mhz    (i_freq_fraction_mhz[8*g +: 8]),
        .i_freq_measure_settled (i_freq_measure_settled[g]),
        .i_low_freq_threshold   (i_low_freq_threshold),
        .i_sensor_valid         (i_sensor_valid[g]),
        .i_sensor_index         (i_sensor_index[g]),
        .i_sensor_data          (i_sensor_data[8*g +: 8]),
        .i_status_read          (status_read[g]),
        .o_status               (p_status[g]),
        .o_freq_integer         (p_fint[g]),
        .o_freq_fraction        (p_ffrac[g]),
        .o_sensor_zero          (p_sens0[g]),
        .o_sensor_one           (p_sens1[g]),
        .o_receiver_locked      (p_lock[g])
      );
    end
  endgenerate

  // Register decode, read mux and port select
  always_comb
  begin
    nxt_st        = st_ff;
    nxt_st.rvalid = i_reg_rd;
    nxt_st.locked = p_lock;
    if (i_reg_wr && i_reg_addr == rpsm_pkg::ADDR_PORT_SELECT)
      nxt_st.port_sel = i_reg_wdata;
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        rpsm_pkg::ADDR_PORT_SELECT:     nxt_st.rdata = st_ff.port_sel;
        rpsm_pkg::ADDR_PORT_STATUS_TWO: nxt_st.rdata = p_status[rd_port];
        rpsm_pkg::ADDR_FREQ_INTEGER:    nxt_st.rdata = p_fint[rd_port];
        rpsm_pkg::ADDR_FREQ_FRACTION:   nxt_st.rdata = p_ffrac[rd_port];
        rpsm_pkg::ADDR_SENSOR_ZERO:     nxt_st.rdata = p_sens0[rd_port];
        rpsm_pkg::ADDR_SENSOR_ONE:      nxt_st.rdata = p_sens1[rd_port];
        default:                        nxt_st.rdata = rpsm_pkg::RST_BYTE;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_ff          <= '0;
      st_ff.port_sel <= rpsm_pkg::RST_SELECT;
    end
    else
      st_ff <= nxt_st;
  end

  assign o_reg_rdata       = st_ff.rdata;
  assign o_reg_rvalid      = st_ff.rvalid;
  assign o_receiver_locked = st_ff.locked;

endmodule

// ---- verification/rpsm_chk.sv ----
`timescale 1ns/1ps
// Register port and lock path checks
module rpsm_chk
(
  // Clock and reset
  input wire logic        i_mclk,
  input wire logic        i_nrst,
  // Register port
  input wire logic        i_reg_rd,
  input wire logic        i_reg_wr,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic        o_reg_rvalid,
  // Watched status sources
  input wire logic [31:0] i_freq_integer_mhz,
  input wire logic [7:0]  i_low_freq_threshold,
  input wire logic [3:0]  i_video_rx_error,
  input wire logic [3:0]  i_receiver_locked,
  input wire logic [3:0]  o_receiver_locked
);
  logic [7:0] sel_ff;
  logic [1:0] up_ff;
  logic [7:0] fint;
  logic       low;
  logic       vrx;
  logic       map;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // Shadow port select, cycles since reset
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sel_ff <= 8'h01;
      up_ff  <= 2'h0;
    end
    else
    begin
      if (i_reg_wr && i_reg_addr == 8'h4c)
        sel_ff <= i_reg_wdata;
      if (up_ff != 2'h3)
        up_ff <= up_ff + 2'h1;
    end
  end
  // Selected port views
  assign fint = 8'(i_freq_integer_mhz >> (8 * sel_ff[7:6]));
  assign low  = fint < i_low_freq_threshold;
  assign vrx  = i_video_rx_error[sel_ff[7:6]];
  assign map  = i_reg_addr inside {8'h4c, [8'h4e:8'h52]};
  a_rvalid_after_rd: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("rvalid missing");
  a_rvalid_needs_rd: assert property (o_reg_rvalid |-> $past(i_reg_rd))
    else $error("rvalid without read");
  a_unmapped_zero: assert property (i_reg_rd && !map |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_select_readback: assert property
    (i_reg_rd && i_reg_addr == 8'h4c |=> o_reg_rdata == $past(sel_ff))
    else $error("port select readback wrong");
  a_freq_int_read: assert property
    (i_reg_rd && i_reg_addr == 8'h4f && $stable(fint) |=> o_reg_rdata == $past(fint))
    else $error("integer frequency wrong");
  a_clock_absent: assert property
    (i_reg_rd && i_reg_addr == 8'h4e && $stable(fint) && $stable(i_low_freq_threshold)
     |=> o_reg_rdata[1] == $past(low))
    else $error("clock absent bit wrong");
  a_video_live: assert property
    (i_reg_rd && i_reg_addr == 8'h4e |=> o_reg_rdata[3] == $past(vrx))
    else $error("video error bit wrong");
  a_lock_delay: assert property
    (up_ff == 2'h3 |-> o_receiver_locked == $past(i_receiver_locked, 2))
    else $error("lock output wrong");
endmodule

bind rpsm_monitor rpsm_chk chk
(
  .i_mclk, .i_nrst, .i_reg_rd, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
  .o_reg_rvalid, .i_freq_integer_mhz, .i_low_freq_threshold, .i_video_rx_error,
  .i_receiver_locked, .o_receiver_locked
);

// ---- verification/rpsm_far.sv ----
`timescale 1ns/1ps
// Remote serializer: video timing and forward-channel status
module rpsm_far
(
  // Clock
  input  wire logic   i_mclk,
  // Link side toward the hub
  output logic [3:0]  o_frame_start,
  output logic [3:0]  o_line_end,
  output logic [63:0] o_line_length,
  output logic [3:0]  o_sensor_valid,
  output logic [3:0]  o_sensor_index,
  output logic [31:0] o_sensor_data
);
  // Idle link
  initial
  begin
    {o_frame_start, o_line_end, o_line_length} = '0;
    {o_sensor_valid, o_sensor_index, o_sensor_data} = '0;
  end
  // Frame of n lines, line 1 one longer when odd
  task automatic frame(input int p, input int n, input logic [15:0] len, input bit odd);
    @(posedge i_mclk);
    #1 o_frame_start[p] = 1'b1;
    @(posedge i_mclk);
    #1 o_frame_start[p] = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      repeat (3) @(posedge i_mclk);
      #1 o_line_end[p] = 1'b1;
      o_line_length[16*p+:16] = len + 16'(odd && i == 1);
      @(posedge i_mclk);
      #1 o_line_end[p] = 1'b0;
      o_line_length[16*p+:16] = ~o_line_length[16*p+:16]; // Stale value
    end
  endtask
  // One status word for a sensor slot
  task automatic sensor(input int p, input logic idx, input logic [7:0] d);
    @(posedge i_mclk);
    #1 o_sensor_valid[p] = 1'b1;
    o_sensor_index[p] = idx;
    o_sensor_data[8*p+:8] = d;
    @(posedge i_mclk);
    #1 o_sensor_valid[p] = 1'b0;
    o_sensor_data[8*p+:8] = ~d;
  endtask
endmodule

// ---- verification/rx_port_status_monitor_tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module rx_port_status_monitor_tb;
  logic        i_mclk, i_nrst, rd, wr, rvalid;
  logic [7:0]  addr, wdata, rdata, thr, d, s0, s1;
  logic [3:0]  enc, ovf, vrx, lck, olck, stl, fs, le, sv, si;
  logic [31:0] fint, ffrac, sd;
  logic [63:0] ll;
  logic [15:0] len;
  logic [7:0]  ra [6] = '{8'h4e, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h4d};
  int          n_mismatch, cmp_count, p;
  rpsm_monitor uut (.i_mclk, .i_nrst, .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_frame_start(fs),
    .i_line_end(le), .i_line_length(ll), .i_encoding_error(enc), .i_buffer_overflow(ovf),
    .i_video_rx_error(vrx), .i_receiver_locked(lck), .i_freq_integer_mhz(fint),
    .i_freq_fraction_mhz(ffrac), .i_freq_measure_settled(stl), .i_low_freq_threshold(thr),
    .i_sensor_valid(sv), .i_sensor_index(si), .i_sensor_data(sd), .o_receiver_locked(olck));
  rpsm_far far (.i_mclk, .o_frame_start(fs), .o_line_end(le), .o_line_length(ll),
    .o_sensor_valid(sv), .o_sensor_index(si), .o_sensor_data(sd));
  // Clock
  initial
  begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  // Expected status byte of port q
  function automatic logic [7:0] sts(input int q, input logic [7:0] stk);
    return stk | {4'h0, vrx[q], stl[q], fint[8*q+:8] < thr, 1'b0};
  endfunction
  // Register read, optionally with events in the same cycle
  task automatic rdr(input logic [7:0] a, input logic ev, output logic [7:0] v);
    @(posedge i_mclk);
    #1 rd = 1'b1;
    addr = a;
    enc[p] = ev;
    ovf[p] = ev;
    @(posedge i_mclk);
    #1 rd = 1'b0;
    {enc, ovf} = '0;
    `CHK(rvalid, 1'b1)
    v = rdata;
  endtask
  // Register write
  task automatic wrr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    #1 wr = 1'b1;
    addr = a;
    wdata = v;
    @(posedge i_mclk);
    #1 wr = 1'b0;
  endtask
  // Verdict and end of run
  task automatic give_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #100000;
    n_mismatch++;
    give_verdict;
  end
  // Main sequence
  initial
  begin
    {rd, wr, addr, wdata, enc, ovf, vrx, lck, fint, ffrac, stl, thr} = '0;
    {i_nrst, n_mismatch, cmp_count, p} = '0;
    d = 8'($urandom(32'h40c5));
    repeat (10) @(posedge i_mclk);
    #1 i_nrst = 1'b1;
    foreach (ra[i])
    begin
      rdr(ra[i], 1'b0, d);
      `CHK(d, 8'h00)
    end
    rdr(8'h4c, 1'b0, d);
    `CHK(d, 8'h01)
    for (p = 0; p < 4; p++)
    begin
      {fint, ffrac, s0, s1} = {$urandom, $urandom, 16'($urandom)};
      {vrx, stl, lck} = 12'($urandom);
      thr = (p == 1) ? fint[15:8] : 8'($urandom); // Threshold equal to port 1 frequency
      wrr(8'h4c, {2'(p), 2'b00, 4'(1 << p)});
      far.sensor(p, 1'b0, s0);
      far.sensor(p, 1'b1, s1);
      rdr(8'h4f, 1'b0, d);
      `CHK(d, fint[8*p+:8])
      rdr(8'h50, 1'b0, d);
      `CHK(d, ffrac[8*p+:8])
      rdr(8'h51, 1'b0, d);
      `CHK(d, s0)
      rdr(8'h52, 1'b0, d);
      `CHK(d, s1)
      `CHK(olck, lck)
      rdr(8'h4e, 1'b1, d);
      rdr(8'h4e, 1'b0, d);
      `CHK(d, sts(p, 8'h30))
      rdr(8'h4e, 1'b0, d);
      `CHK(d, sts(p, 8'h00))
    end
    p = 3;
    len = 16'($urandom);
    repeat (3) far.frame(p, 3, len, 1'b0);
    rdr(8'h4e, 1'b0, d);
    far.frame(p, 3, len, 1'b0);
    rdr(8'h4e, 1'b0, d);
    `CHK(d, sts(p, 8'h00))
    far.frame(p, 4, len, 1'b1);
    far.frame(p, 0, len, 1'b0);
    rdr(8'h4e, 1'b0, d);
    `CHK(d, sts(p, 8'hc1))
    rdr(8'h4e, 1'b0, d);
    `CHK(d, sts(p, 8'h00))
    give_verdict;
  end
endmodule
